// ### design/dam_pkg.sv
// Purpose: Shared constants for the dual alarm event monitor
// Assumes: 16-bit registers at even byte addresses, 14-bit source data
// Notes: Constants only, no logic
package dam_pkg;

	// --------------------------------------------------------------
	// Widths and counts
	// --------------------------------------------------------------
	localparam int DAM_DATA_W = 14;
	localparam int DAM_NUM_SRC = 11;
	localparam int DAM_REG_W = 16;
	localparam int DAM_ADDR_W = 8;
	localparam int DAM_CNT_W = 8;
	localparam int DAM_DIFF_W = 15;
	localparam int DAM_DIV_STEPS = 15;

	// --------------------------------------------------------------
	// Register byte addresses
	// --------------------------------------------------------------
	localparam logic [7:0] DAM_ADDR_THR_ONE = 8'h26;
	localparam logic [7:0] DAM_ADDR_THR_TWO = 8'h28;
	localparam logic [7:0] DAM_ADDR_CNT_ONE = 8'h2a;
	localparam logic [7:0] DAM_ADDR_CNT_TWO = 8'h2c;
	localparam logic [7:0] DAM_ADDR_CTRL = 8'h2e;
	localparam logic [7:0] DAM_ADDR_STATUS = 8'h3c;

	// --------------------------------------------------------------
	// Reset values and writable masks
	// --------------------------------------------------------------
	localparam logic [15:0] DAM_RST_THR = 16'h0000;
	localparam logic [7:0] DAM_RST_CNT = 8'h00;
	localparam logic [15:0] DAM_RST_CTRL = 16'h0000;
	localparam logic [15:0] DAM_MASK_THR = 16'hbfff;
	localparam logic [15:0] DAM_MASK_CTRL = 16'hffd7;

	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int DAM_THR_DIR_BIT = 15;
	localparam int DAM_SRC_TWO_LSB = 12;
	localparam int DAM_SRC_ONE_LSB = 8;
	localparam int DAM_SRC_W = 4;
	localparam int DAM_ROC_ONE_BIT = 6;
	localparam int DAM_FILT_BIT = 4;
	localparam int DAM_OUT_EN_BIT = 2;
	localparam int DAM_OUT_POL_BIT = 1;
	localparam int DAM_OUT_SEL_BIT = 0;
	localparam int DAM_STAT_ONE_BIT = 8;

	// --------------------------------------------------------------
	// Source codes and limits
	// --------------------------------------------------------------
	localparam logic [3:0] DAM_SRC_DISABLE = 4'h0;
	localparam logic [3:0] DAM_SRC_LAST = 4'hb;
	localparam logic [14:0] DAM_RATE_MAX = 15'h1fff;

endpackage : dam_pkg

// ### design/dam_compare.sv
// Purpose: Threshold comparison for one alarm channel
// Assumes: Value and threshold magnitude are 14-bit two's complement
// Notes: Combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module dam_compare import dam_pkg::*; #(
	parameter int DW = DAM_DATA_W
) (
	// Operands
	input wire logic signed [DW-1:0] value,
	input wire logic [DAM_REG_W-1:0] threshold,
	// Result
	output logic hit
);
	logic signed [DW-1:0] level;

	assign level = signed'(threshold[DW-1:0]);
	assign hit = threshold[DAM_THR_DIR_BIT] ? (value > level) : (value < level);
endmodule : dam_compare
`default_nettype wire

// ### design/dam_roc_avg.sv
// Purpose: Averaged rate of change over a programmable number of deltas
// Assumes: Update ticks are far apart compared to the divider run time
// Notes: Sum of N successive deltas telescopes to last minus first sample
`timescale 1ns/100ps
`default_nettype none
module dam_roc_avg import dam_pkg::*; #(
	parameter int DW = DAM_DATA_W,
	parameter int CW = DAM_CNT_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Sampling
	input wire logic tick,
	input wire logic enable,
	input wire logic signed [DW-1:0] sample,
	input wire logic [CW-1:0] num_deltas,
	// Result
	output logic signed [DW-1:0] rate,
	output logic rate_valid
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DIV = 3'b010,
		ST_DONE = 3'b100
	} dam_div_state_t;

	dam_div_state_t state;
	logic started;
	logic signed [DW-1:0] base;
	logic [CW-1:0] count;
	logic [CW-1:0] divisor;
	logic [CW-1:0] target;
	logic [DAM_DIFF_W-1:0] quo;
	logic [CW:0] rem;
	logic [CW:0] next_rem;
	logic [4:0] step;
	logic negative;
	logic signed [DAM_DIFF_W-1:0] diff;
	logic launch;

	// A zero count is taken as one delta
	assign target = (num_deltas == '0) ? CW'(1) : num_deltas;
	assign diff = DAM_DIFF_W'(sample) - DAM_DIFF_W'(base);
	assign launch = tick && enable && started && (count + CW'(1) >= target);
	assign next_rem = {rem[CW-1:0], quo[DAM_DIFF_W-1]};

	// --------------------------------------------------------------
	// Delta window
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst || !enable) begin
			started <= 1'b0;
			base <= '0;
			count <= '0;
		end else if (tick) begin
			started <= 1'b1;
			if (!started || launch) begin
				base <= sample;
				count <= '0;
			end else begin
				count <= count + CW'(1);
			end
		end
	end

	// --------------------------------------------------------------
	// Sequential divider
	// --------------------------------------------------------------
	// A window ending while the divider is busy is dropped
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state <= ST_IDLE;
			quo <= '0;
			rem <= '0;
			divisor <= '0;
			step <= '0;
			negative <= 1'b0;
			rate <= '0;
			rate_valid <= 1'b0;
		end else begin
			rate_valid <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (launch) begin
						negative <= diff[DAM_DIFF_W-1];
						quo <= diff[DAM_DIFF_W-1] ? DAM_DIFF_W'(-diff) : diff;
						rem <= '0;
						divisor <= target;
						step <= '0;
						state <= ST_DIV;
					end
				end
				ST_DIV: begin
					if (next_rem >= {1'b0, divisor}) begin
						rem <= next_rem - {1'b0, divisor};
						quo <= {quo[DAM_DIFF_W-2:0], 1'b1};
					end else begin
						rem <= next_rem;
						quo <= {quo[DAM_DIFF_W-2:0], 1'b0};
					end
					step <= step + 5'd1;
					if (step == 5'(DAM_DIV_STEPS - 1)) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (quo > DAM_RATE_MAX) begin
						rate <= negative ? DW'(-DAM_RATE_MAX) : DW'(DAM_RATE_MAX);
					end else begin
						rate <= negative ? DW'(-quo) : DW'(quo);
					end
					rate_valid <= 1'b1;
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule : dam_roc_avg
`default_nettype wire

// ### design/dam_alarm_monitor.sv
// Purpose: Two alarm channels watching selectable output data
// Assumes: Register port and update tick come from logic on clk_sys
// Notes: Status read returns only the two alarm bits of the status word
`timescale 1ns/100ps
`default_nettype none

module dam_alarm_monitor import dam_pkg::*; #(
	parameter int DW = DAM_DATA_W,
	parameter int NSRC = DAM_NUM_SRC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Output data update
	input wire logic update_tick,
	input wire logic [NSRC*DW-1:0] src_filtered,
	input wire logic [NSRC*DW-1:0] src_raw,
	// Register port
	input wire logic [DAM_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DAM_REG_W-1:0] reg_wdata,
	output logic [DAM_REG_W-1:0] reg_rdata,
	// General pins
	output logic general_pin_one_out,
	output logic general_pin_one_oe,
	output logic general_pin_two_out,
	output logic general_pin_two_oe,
	// Live alarm state
	output logic [1:0] alarm_active
);
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic src_enabled(input logic [DAM_SRC_W-1:0] code);
		return (code != DAM_SRC_DISABLE) && (code <= DAM_SRC_LAST);
	endfunction : src_enabled

	function automatic logic signed [DW-1:0] src_pick(
		input logic [NSRC*DW-1:0] bank,
		input logic [DAM_SRC_W-1:0] code
	);
		logic signed [DW-1:0] val;
		val = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (code == DAM_SRC_W'(i + 1)) begin
				val = bank[i*DW +: DW];
			end
		end
		return val;
	endfunction : src_pick

	// One-hot select of the mapped register words
	typedef struct packed {
		logic status;
		logic ctrl;
		logic cnt_two;
		logic cnt_one;
		logic thr_two;
		logic thr_one;
	} dam_reg_sel_t;

	function automatic dam_reg_sel_t reg_decode(input logic [DAM_ADDR_W-1:0] addr);
		dam_reg_sel_t sel;
		sel = '0;
		sel.thr_one = (addr == DAM_ADDR_THR_ONE);
		sel.thr_two = (addr == DAM_ADDR_THR_TWO);
		sel.cnt_one = (addr == DAM_ADDR_CNT_ONE);
		sel.cnt_two = (addr == DAM_ADDR_CNT_TWO);
		sel.ctrl = (addr == DAM_ADDR_CTRL);
		sel.status = (addr == DAM_ADDR_STATUS);
		return sel;
	endfunction : reg_decode

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	logic [DAM_REG_W-1:0] thr [2];
	logic [DAM_CNT_W-1:0] cnt [2];
	logic [DAM_REG_W-1:0] ctrl;
	logic [1:0] stat_flag;
	logic [1:0] eval_stb;
	logic [1:0] eval_hit;
	logic [1:0] flag_set;
	logic status_read;
	logic [NSRC*DW-1:0] bank;
	logic [1:0] next_alarm_active;
	dam_reg_sel_t wr_sel;
	dam_reg_sel_t rd_sel;

	// Decode once so the write and clear paths cannot disagree on a word
	assign wr_sel = reg_wr ? reg_decode(reg_addr) : dam_reg_sel_t'('0);
	assign rd_sel = reg_decode(reg_addr);
	assign status_read = reg_rd && rd_sel.status;
	assign bank = ctrl[DAM_FILT_BIT] ? src_filtered : src_raw;

	// Reserved bits are masked on the way in and read back as zero
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			thr[0] <= DAM_RST_THR;
			thr[1] <= DAM_RST_THR;
			cnt[0] <= DAM_RST_CNT;
			cnt[1] <= DAM_RST_CNT;
			ctrl <= DAM_RST_CTRL;
		end else begin
			if (wr_sel.thr_one) begin
				thr[0] <= reg_wdata & DAM_MASK_THR;
			end
			if (wr_sel.thr_two) begin
				thr[1] <= reg_wdata & DAM_MASK_THR;
			end
			if (wr_sel.cnt_one) begin
				cnt[0] <= reg_wdata[DAM_CNT_W-1:0];
			end
			if (wr_sel.cnt_two) begin
				cnt[1] <= reg_wdata[DAM_CNT_W-1:0];
			end
			if (wr_sel.ctrl) begin
				ctrl <= reg_wdata & DAM_MASK_CTRL;
			end
		end
	end

	// Unmapped addresses read as zero
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				DAM_ADDR_THR_ONE: reg_rdata <= thr[0];
				DAM_ADDR_THR_TWO: reg_rdata <= thr[1];
				DAM_ADDR_CNT_ONE: reg_rdata <= DAM_REG_W'(cnt[0]);
				DAM_ADDR_CNT_TWO: reg_rdata <= DAM_REG_W'(cnt[1]);
				DAM_ADDR_CTRL: reg_rdata <= ctrl;
				DAM_ADDR_STATUS: reg_rdata <= DAM_REG_W'(stat_flag) << DAM_STAT_ONE_BIT;
				default: reg_rdata <= '0;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Alarm channels
	// --------------------------------------------------------------
	// Each channel owns its averager; the channels share only the data bank
	for (genvar g = 0; g < 2; g++) begin : g_chan
		logic [DAM_SRC_W-1:0] code;
		logic enabled;
		logic roc_mode;
		logic signed [DW-1:0] sample;
		logic signed [DW-1:0] rate;
		logic rate_valid;
		logic hit_static;
		logic hit_rate;

		// Alarm two field sits above alarm one
		assign code = ctrl[(g == 0 ? DAM_SRC_ONE_LSB : DAM_SRC_TWO_LSB) +: DAM_SRC_W];
		assign enabled = src_enabled(code);
		assign roc_mode = ctrl[DAM_ROC_ONE_BIT + g];
		assign sample = src_pick(bank, code);

		dam_roc_avg #(
			.DW(DW),
			.CW(DAM_CNT_W)
		) u_roc (
			.clk_sys(clk_sys),
			.nrst(nrst),
			.tick(update_tick),
			.enable(enabled && roc_mode),
			.sample(sample),
			.num_deltas(cnt[g]),
			.rate(rate),
			.rate_valid(rate_valid)
		);

		dam_compare #(
			.DW(DW)
		) u_cmp_static (
			.value(sample),
			.threshold(thr[g]),
			.hit(hit_static)
		);

		dam_compare #(
			.DW(DW)
		) u_cmp_rate (
			.value(rate),
			.threshold(thr[g]),
			.hit(hit_rate)
		);

		// Rate mode evaluates when a window's average is ready
		always_comb begin
			if (!enabled) begin
				eval_stb[g] = update_tick;
				eval_hit[g] = 1'b0;
			end else if (roc_mode) begin
				eval_stb[g] = rate_valid;
				eval_hit[g] = hit_rate;
			end else begin
				eval_stb[g] = update_tick;
				eval_hit[g] = hit_static;
			end
		end
	end

	// --------------------------------------------------------------
	// Live state and status flags
	// --------------------------------------------------------------
	always_comb begin
		next_alarm_active = alarm_active;
		for (int i = 0; i < 2; i++) begin
			if (eval_stb[i]) begin
				next_alarm_active[i] = eval_hit[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			alarm_active <= 2'b00;
		end else begin
			alarm_active <= next_alarm_active;
		end
	end

	// Static and disabled channels settle on every tick; only a rate alarm
	// between windows keeps its flag alive through its held state
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (eval_stb[i]) begin
				flag_set[i] = eval_hit[i];
			end else begin
				flag_set[i] = update_tick && alarm_active[i];
			end
		end
	end

	// Set beats the clear of a status read in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			stat_flag <= 2'b00;
		end else begin
			stat_flag <= (status_read ? 2'b00 : stat_flag) | flag_set;
		end
	end

	// --------------------------------------------------------------
	// Pin drive
	// --------------------------------------------------------------
	// Out is held low while released so the pad never sees a stale level
	function automatic logic [1:0] pin_drive(
		input logic enable,
		input logic routed,
		input logic level
	);
		logic drive;
		drive = enable && routed;
		return {drive, drive && level};
	endfunction : pin_drive

	logic any_active;
	logic pin_level;
	logic out_en;
	logic out_sel;
	logic [1:0] next_pin_one;
	logic [1:0] next_pin_two;

	assign any_active = |alarm_active;
	assign pin_level = ctrl[DAM_OUT_POL_BIT] ? any_active : ~any_active;
	assign out_en = ctrl[DAM_OUT_EN_BIT];
	assign out_sel = ctrl[DAM_OUT_SEL_BIT];
	assign next_pin_one = pin_drive(out_en, !out_sel, pin_level);
	assign next_pin_two = pin_drive(out_en, out_sel, pin_level);

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			general_pin_one_out <= 1'b0;
			general_pin_one_oe <= 1'b0;
			general_pin_two_out <= 1'b0;
			general_pin_two_oe <= 1'b0;
		end else begin
			general_pin_one_oe <= next_pin_one[1];
			general_pin_two_oe <= next_pin_two[1];
			general_pin_one_out <= next_pin_one[0];
			general_pin_two_out <= next_pin_two[0];
		end
	end
endmodule : dam_alarm_monitor
`default_nettype wire

// ### testbench/dam_alarm_sva.sv
// Purpose: Port assertions for the alarm monitor
// Assumes: Register mirrors follow the write strobe
// Notes: Rate mode results are left to the bench
`timescale 1ns/100ps
`default_nettype none
module dam_alarm_sva import dam_pkg::*; #(
	parameter int DW = DAM_DATA_W,
	parameter int NSRC = DAM_NUM_SRC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Stimulus side
	input wire logic update_tick,
	input wire logic [NSRC*DW-1:0] src_filtered,
	input wire logic [NSRC*DW-1:0] src_raw,
	input wire logic [DAM_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DAM_REG_W-1:0] reg_wdata,
	// Design outputs
	input wire logic [DAM_REG_W-1:0] reg_rdata,
	input wire logic general_pin_one_out,
	input wire logic general_pin_one_oe,
	input wire logic general_pin_two_out,
	input wire logic general_pin_two_oe,
	input wire logic [1:0] alarm_active
);
	// ------------------------------------------------------------
	// Mirrors and expected hits
	// ------------------------------------------------------------
	logic [15:0] thr1, thr2, ctl;
	logic [1:0] exp_hit;
	function automatic logic hit(logic [NSRC*DW-1:0] b, logic [3:0] c, logic [15:0] t);
		logic signed [DW-1:0] v;
		if (c == 4'h0 || c > 4'hb) return 1'b0;
		v = b[(int'(c) - 1)*DW +: DW];
		return t[15] ? v > $signed(t[DW-1:0]) : v < $signed(t[DW-1:0]);
	endfunction : hit
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			thr1 <= 16'h0000;
			thr2 <= 16'h0000;
			ctl <= 16'h0000;
		end else if (reg_wr) begin
			if (reg_addr == DAM_ADDR_THR_ONE) thr1 <= reg_wdata & DAM_MASK_THR;
			if (reg_addr == DAM_ADDR_THR_TWO) thr2 <= reg_wdata & DAM_MASK_THR;
			if (reg_addr == DAM_ADDR_CTRL) ctl <= reg_wdata & DAM_MASK_CTRL;
		end
	end
	// Sampled at the tick edge, before any write lands
	always_ff @(posedge clk_sys) begin
		exp_hit[0] <= hit(ctl[4] ? src_filtered : src_raw, ctl[11:8], thr1);
		exp_hit[1] <= hit(ctl[4] ? src_filtered : src_raw, ctl[15:12], thr2);
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_stat_rd;
		reg_rd && reg_addr == DAM_ADDR_STATUS;
	endsequence
	// Rate results may land without a tick, so only static mode
	sequence s_quiet_rd;
		reg_rd && reg_addr == DAM_ADDR_STATUS && !update_tick && ctl[7:6] == 2'b00;
	endsequence
	chk_oe_one_gate: assert property (general_pin_one_oe == $past(ctl[2] && !ctl[0]))
		else $error("pin one enable wrong");
	chk_oe_two_gate: assert property (general_pin_two_oe == $past(ctl[2] && ctl[0]))
		else $error("pin two enable wrong");
	chk_pin_one_level: assert property (general_pin_one_out ==
		$past(ctl[2] && !ctl[0] && ((|alarm_active) == ctl[1]))) else $error("pin one level");
	chk_pin_two_level: assert property (general_pin_two_out ==
		$past(ctl[2] && ctl[0] && ((|alarm_active) == ctl[1]))) else $error("pin two level");
	chk_ctrl_read_back: assert property (reg_rd && !reg_wr && reg_addr == DAM_ADDR_CTRL
		|=> reg_rdata == ctl) else $error("control read back wrong");
	chk_status_bits_only: assert property (s_stat_rd |=> reg_rdata[15:10] == 6'h00
		&& reg_rdata[7:0] == 8'h00) else $error("status spare bits set");
	chk_status_read_clear: assert property (!update_tick ##1 s_quiet_rd ##1 !update_tick
		##1 s_stat_rd |=> reg_rdata == 16'h0000) else $error("status not cleared by read");
	chk_static_one_hit: assert property (update_tick && !ctl[6]
		|=> alarm_active[0] == exp_hit[0]) else $error("alarm one static result");
	chk_static_two_hit: assert property (update_tick && !ctl[7]
		|=> alarm_active[1] == exp_hit[1]) else $error("alarm two static result");
endmodule : dam_alarm_sva
bind dam_alarm_monitor dam_alarm_sva #(.DW(DW), .NSRC(NSRC)) u_sva (.clk_sys(clk_sys),
	.nrst(nrst), .update_tick(update_tick), .src_filtered(src_filtered), .src_raw(src_raw),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .general_pin_one_out(general_pin_one_out),
	.general_pin_one_oe(general_pin_one_oe), .general_pin_two_out(general_pin_two_out),
	.general_pin_two_oe(general_pin_two_oe), .alarm_active(alarm_active));
`default_nettype wire

// ### testbench/dam_host_pins.sv
// Purpose: Host view of the two general pins
// Assumes: Board pull-ups on both pins
// Notes: A released pin reads high, never a stale value
`timescale 1ns/100ps
`default_nettype none
module dam_host_pins (
	// Pin drive from the monitor
	input wire logic pin_one_out,
	input wire logic pin_one_oe,
	input wire logic pin_two_out,
	input wire logic pin_two_oe,
	// Levels seen by the host
	output logic pin_one_level,
	output logic pin_two_level
);
	assign pin_one_level = pin_one_oe ? pin_one_out : 1'b1;
	assign pin_two_level = pin_two_oe ? pin_two_out : 1'b1;
endmodule : dam_host_pins
`default_nettype wire

// ### testbench/dam_alarm_monitor_tb_top.sv
// Purpose: Register level tests of the alarm monitor
// Assumes: Pull-ups on both general pins
// Notes: Rate ticks sit 22 cycles apart, past the divider
`timescale 1ns/100ps
`default_nettype none
module dam_alarm_monitor_tb_top import dam_pkg::*;;
	logic clk_sys, nrst, update_tick, reg_wr, reg_rd, lvl1, lvl2, p1o, p1e, p2o, p2e;
	logic [DAM_NUM_SRC*DAM_DATA_W-1:0] src_filtered, src_raw;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, ctl, msk;
	logic [1:0] alarm_active;
	int err_total, checks_done, i, k;
	dam_alarm_monitor u_dut (.clk_sys(clk_sys), .nrst(nrst), .update_tick(update_tick),
		.src_filtered(src_filtered), .src_raw(src_raw), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.general_pin_one_out(p1o), .general_pin_one_oe(p1e), .general_pin_two_out(p2o),
		.general_pin_two_oe(p2e), .alarm_active(alarm_active));
	dam_host_pins u_host (.pin_one_out(p1o), .pin_one_oe(p1e), .pin_two_out(p2o),
		.pin_two_oe(p2e), .pin_one_level(lvl1), .pin_two_level(lvl2));
	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata, exp);
	endtask : rdc
	// Word for code c changes at the tick edge itself
	task automatic tick(input int c, input logic [13:0] f, input logic [13:0] r, input int n);
		@(posedge clk_sys);
		src_filtered[(c-1)*DAM_DATA_W +: DAM_DATA_W] <= f;
		src_raw[(c-1)*DAM_DATA_W +: DAM_DATA_W] <= r;
		update_tick <= 1'b1;
		@(posedge clk_sys);
		update_tick <= 1'b0;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic end_sim();
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	// ------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		#20000;
		err_total++;
		end_sim();
	end
	initial begin
		nrst = 1'b0;
		update_tick = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		src_filtered = '0;
		src_raw = '0;
		err_total = 0;
		checks_done = 0;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		for (i = 0; i < 5; i++) begin
			msk = i < 2 ? DAM_MASK_THR : (i < 4 ? 16'h00ff : DAM_MASK_CTRL);
			rdc(8'h26 + 8'(2 * i), 16'h0000);
			wr(8'h26 + 8'(2 * i), 16'hffff);
			rdc(8'h26 + 8'(2 * i), msk);
		end
		wr(8'h30, 16'hffff);
		rdc(8'h30, 16'h0000);
		rdc(DAM_ADDR_STATUS, 16'h0000);
		wr(DAM_ADDR_THR_ONE, 16'h8010);
		wr(DAM_ADDR_THR_TWO, 16'h0000);
		for (k = 1; k < 12; k++) begin
			ctl = {4'(k), 4'(k), 8'h16};
			wr(DAM_ADDR_CTRL, ctl);
			tick(k, 14'h0014, 14'h3fec, 2);
			cmp({14'h0, alarm_active}, 16'h0001);
			cmp({14'h0, lvl1, lvl2}, 16'h0003);
			rdc(DAM_ADDR_STATUS, 16'h0100);
			wr(DAM_ADDR_CTRL, ctl & 16'hffef);
			tick(k, 14'h0014, 14'h3fec, 2);
			cmp({14'h0, alarm_active}, 16'h0002);
			rdc(DAM_ADDR_STATUS, 16'h0200);
		end
		rdc(DAM_ADDR_STATUS, 16'h0000);
		tick(1, 14'h0014, 14'h3fec, 2);
		rdc(DAM_ADDR_STATUS, 16'h0200);
		for (k = 12; k < 17; k++) begin
			wr(DAM_ADDR_CTRL, {4'(k), 4'(k), 8'h16});
			tick(1, 14'h0014, 14'h3fec, 2);
			cmp({14'h0, alarm_active}, 16'h0000);
			cmp({15'h0, lvl1}, 16'h0000);
		end
		for (i = 0; i < 16; i++) begin
			ctl = 16'h0110 | 16'(i % 8);
			wr(DAM_ADDR_CTRL, ctl);
			tick(1, i > 7 ? 14'h0014 : 14'h000a, 14'h0000, 2);
			cmp({15'h0, lvl1}, ctl[2] && !ctl[0] ? 16'(!((i > 7) ^ ctl[1])) : 16'h1);
			cmp({15'h0, lvl2}, ctl[2] && ctl[0] ? 16'(!((i > 7) ^ ctl[1])) : 16'h1);
		end
		tick(1, 14'h0000, 14'h0000, 2);
		wr(DAM_ADDR_CNT_ONE, 16'h0004);
		wr(DAM_ADDR_CNT_TWO, 16'h0004);
		wr(DAM_ADDR_THR_ONE, 16'h8004);
		wr(DAM_ADDR_THR_TWO, 16'h0005);
		wr(DAM_ADDR_CTRL, 16'h11d0);
		for (k = 0; k < 5; k++) tick(1, 14'(25 * k), 14'h0000, 20);
		cmp({14'h0, alarm_active}, 16'h0001);
		for (k = 1; k < 5; k++) tick(1, k == 4 ? 14'h0077 : 14'(100 + 4 * k), 14'h0000, 20);
		cmp({14'h0, alarm_active}, 16'h0002);
		end_sim();
	end
endmodule : dam_alarm_monitor_tb_top
`default_nettype wire
